/* rtl/apt_axis.sv */
// One axis: position counters, compare and soft limits, speed ramp and register slave
`timescale 1ns/1ps
module apt_axis (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic enc_a,
  input wire logic enc_b,
  output logic drive_pulse,
  output logic drive_dir
);
  apt_pkg::apt_axis_state_type state_reg;
  apt_pkg::apt_axis_state_type state_next;
  logic pulse_rise;
  logic enc_up;
  logic enc_down;
  logic [31:0] sel_pos;
  logic above_upper;
  logic below_lower;
  logic busy;
  logic ring_on;
  logic req;
  logic wr_take;
  logic cmd_wr;
  logic start_pos;
  logic start_neg;
  logic cmd_decel;
  logic cmd_halt;
  logic [32:0] ramp_v;
  logic [55:0] jerk_sum;
  logic [55:0] jerk_thr;

  // Byte-lane merge shared by every writable register wider than a byte
  // Unwritten lanes keep their old bytes, so narrow host writes are safe
  function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Up count with optional ring maximum
  function automatic logic [31:0] count_inc(logic [31:0] v, logic [31:0] max, logic ring);
    if (ring && v == max) begin
      return 32'h00000000;
    end
    return v + 32'h00000001;
  endfunction

  // Down count with optional ring maximum
  function automatic logic [31:0] count_dec(logic [31:0] v, logic [31:0] max, logic ring);
    if (ring && v == 32'h00000000) begin
      return max;
    end
    return v - 32'h00000001;
  endfunction

  // Speed fraction accumulator; carry out means one speed unit has elapsed
  // Ticks per second is the divisor, so the carry rate is the acceleration in units
  function automatic logic [32:0] ramp_step(logic [31:0] acc, logic [15:0] rate);
    logic [31:0] sum;
    sum = acc + 32'(rate) * apt_pkg::ACCEL_SCALE;
    if (sum >= apt_pkg::SCLK_HZ) begin
      return {1'b1, sum - apt_pkg::SCLK_HZ};
    end
    return {1'b0, sum};
  endfunction

  // Pulse output stage; its rise strobe steps the logical counter
  apt_pulse_gen u_pulse (
    .clock(clock),
    .nrst(nrst),
    .sclk_tick(state_reg.tick),
    .run(state_reg.run),
    .speed(state_reg.speed),
    .range(state_reg.range),
    .pulse_level(drive_pulse),
    .pulse_rise(pulse_rise)
  );

  // Encoder pins are asynchronous and are synchronised inside the decoder
  apt_enc_decode u_enc (
    .clock(clock),
    .nrst(nrst),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .updown_mode(state_reg.input_mode),
    .count_up(enc_up),
    .count_down(enc_down)
  );

  // Compare against the chosen counter, signed
  // Both tests are strict: a count equal to a bound raises neither flag
  assign sel_pos = state_reg.wr2[apt_pkg::CMP_SRC_BIT] ? state_reg.rpos : state_reg.lpos;
  assign above_upper = $signed(sel_pos) > $signed(state_reg.upper);
  assign below_lower = $signed(sel_pos) < $signed(state_reg.lower);
  assign busy = state_reg.state != apt_pkg::ST_IDLE;
  assign ring_on = state_reg.wr3[apt_pkg::RING_BIT];

  // Bus decode: one wait cycle, the write lands on the edge after the wait, when waitrequest is low
  // A read answers with the value latched when the request was first seen
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~state_reg.ack;
  assign wr_take = avs_write & state_reg.ack;
  assign cmd_wr = wr_take && avs_address == apt_pkg::OFS_COMMAND && avs_byteenable[0];
  assign start_pos = cmd_wr & avs_writedata[apt_pkg::CMD_POS_BIT];
  assign start_neg = cmd_wr & avs_writedata[apt_pkg::CMD_NEG_BIT];
  assign cmd_decel = cmd_wr & avs_writedata[apt_pkg::CMD_DECEL_BIT];
  assign cmd_halt = cmd_wr & avs_writedata[apt_pkg::CMD_HALT_BIT];

  // Shared ramp arithmetic for the speed and the S-curve acceleration
  // Both accumulators keep their residue, so rounding never builds up
  assign ramp_v = ramp_step(state_reg.acc_v, state_reg.cur_accel);
  assign jerk_sum = state_reg.acc_j + apt_pkg::JERK_NUM;
  assign jerk_thr = 56'(state_reg.jerk) * 56'(apt_pkg::ACCEL_SCALE) * 56'(apt_pkg::SCLK_HZ);

  always_comb begin
    state_next = state_reg;
    state_next.ack = req & ~state_reg.ack;
    // Timebase tick every second core clock
    state_next.tick = ~state_reg.tick;

    // Live compare flags
    state_next.upper_flag = above_upper;
    state_next.lower_flag = below_lower;

    // Limit flags: setting is checked first so a new hit is never lost
    // A flag outlives the stop it caused until the count is back inside its bound
    if (state_reg.wr2[apt_pkg::POS_LIMIT_EN_BIT] && busy && above_upper) begin
      state_next.pos_lim = 1'b1;
    end else if (!above_upper) begin
      state_next.pos_lim = 1'b0;
    end
    if (state_reg.wr2[apt_pkg::NEG_LIMIT_EN_BIT] && busy && below_lower) begin
      state_next.neg_lim = 1'b1;
    end else if (!below_lower) begin
      state_next.neg_lim = 1'b0;
    end

    // Logical counter follows emitted pulses; ring max is the upper bound
    if (pulse_rise) begin
      if (state_reg.dir) begin
        state_next.lpos = count_dec(state_reg.lpos, state_reg.upper, ring_on);
      end else begin
        state_next.lpos = count_inc(state_reg.lpos, state_reg.upper, ring_on);
      end
    end
    // Real counter follows the encoder; ring max is the lower bound
    // Only in up/down mode can the decoder raise both strobes; up then takes priority and the down count is lost
    if (enc_up) begin
      state_next.rpos = count_inc(state_reg.rpos, state_reg.lower, ring_on);
    end else if (enc_down) begin
      state_next.rpos = count_dec(state_reg.rpos, state_reg.lower, ring_on);
    end

    // Drive sequencing; the timebase tick paces the ramps
    unique case (state_reg.state)
      // A start while busy is ignored; both direction bits give positive travel
      apt_pkg::ST_IDLE: begin
        if (start_pos || start_neg) begin
          state_next.state = apt_pkg::ST_RUN;
          state_next.dir = start_neg & ~start_pos;
          state_next.speed = state_reg.init_speed;
          state_next.acc_v = '0;
          state_next.acc_j = '0;
          state_next.cur_accel = state_reg.wr3[apt_pkg::SCURVE_BIT] ? 16'h0000 : state_reg.accel;
          state_next.run = 1'b1;
        end
      end

      apt_pkg::ST_RUN: begin
        // Halt beats a decelerating stop when both arrive together
        if (cmd_halt) begin
          state_next.state = apt_pkg::ST_DRAIN;
          state_next.run = 1'b0;
        end else if (cmd_decel || state_reg.pos_lim || state_reg.neg_lim) begin
          // Limits stop in either direction of travel
          state_next.state = apt_pkg::ST_DECEL;
          state_next.cur_accel = state_reg.accel;
          state_next.acc_v = '0;
        end else if (state_reg.tick) begin
          // Jerk raises the acceleration one unit per threshold crossing
          if (!state_reg.wr3[apt_pkg::SCURVE_BIT]) begin
            state_next.cur_accel = state_reg.accel;
          end else if (state_reg.cur_accel < state_reg.accel) begin
            if (jerk_sum >= jerk_thr) begin
              state_next.acc_j = jerk_sum - jerk_thr;
              state_next.cur_accel = state_reg.cur_accel + 16'h0001;
            end else begin
              state_next.acc_j = jerk_sum;
            end
          end
          // Speed moves toward the target at the current rate
          if (state_reg.speed != state_reg.drive_speed) begin
            state_next.acc_v = ramp_v[31:0];
            if (ramp_v[32]) begin
              if (state_reg.speed < state_reg.drive_speed) begin
                state_next.speed = state_reg.speed + 16'h0001;
              end else begin
                state_next.speed = state_reg.speed - 16'h0001;
              end
            end
          end
        end
      end

      apt_pkg::ST_DECEL: begin
        // Ramp down at the linear rate until the initial speed is reached
        if (cmd_halt || state_reg.speed <= state_reg.init_speed) begin
          state_next.state = apt_pkg::ST_DRAIN;
          state_next.run = 1'b0;
        end else if (state_reg.tick) begin
          state_next.acc_v = ramp_v[31:0];
          if (ramp_v[32]) begin
            state_next.speed = state_reg.speed - 16'h0001;
          end
        end
      end

      apt_pkg::ST_DRAIN: begin
        // Let a high half period finish so the last pulse is whole
        if (!drive_pulse) begin
          state_next.state = apt_pkg::ST_IDLE;
        end
      end
    endcase

    // Read answer is latched on the first cycle of a request
    // Unmapped offsets and the write-only command word read as zero
    if (avs_read && !state_reg.ack) begin
      case (avs_address)
        apt_pkg::OFS_LPOS: state_next.rdata = state_reg.lpos;
        apt_pkg::OFS_RPOS: state_next.rdata = state_reg.rpos;
        apt_pkg::OFS_UPPER: state_next.rdata = state_reg.upper;
        apt_pkg::OFS_LOWER: state_next.rdata = state_reg.lower;
        apt_pkg::OFS_WR2: state_next.rdata = {24'h000000, state_reg.wr2};
        apt_pkg::OFS_WR3: state_next.rdata = {24'h000000, state_reg.wr3};
        apt_pkg::OFS_RR1: state_next.rdata = {29'h00000000, busy, state_reg.lower_flag, state_reg.upper_flag};
        apt_pkg::OFS_RR2: state_next.rdata = {30'h00000000, state_reg.neg_lim, state_reg.pos_lim};
        apt_pkg::OFS_RANGE: state_next.rdata = {8'h00, state_reg.range};
        apt_pkg::OFS_ACCEL: state_next.rdata = {16'h0000, state_reg.accel};
        apt_pkg::OFS_JERK: state_next.rdata = {16'h0000, state_reg.jerk};
        apt_pkg::OFS_INIT_SPEED: state_next.rdata = {16'h0000, state_reg.init_speed};
        apt_pkg::OFS_DRIVE_SPEED: state_next.rdata = {16'h0000, state_reg.drive_speed};
        apt_pkg::OFS_INPUT_MODE: state_next.rdata = {31'h00000000, state_reg.input_mode};
        apt_pkg::OFS_CUR_SPEED: state_next.rdata = {16'h0000, state_reg.speed};
        default: state_next.rdata = 32'h00000000;
      endcase
    end

    // Host writes override counting in the same cycle
    if (wr_take) begin
      case (avs_address)
        apt_pkg::OFS_LPOS: state_next.lpos = be_merge(state_reg.lpos, avs_writedata, avs_byteenable);
        apt_pkg::OFS_RPOS: state_next.rpos = be_merge(state_reg.rpos, avs_writedata, avs_byteenable);
        apt_pkg::OFS_UPPER: state_next.upper = be_merge(state_reg.upper, avs_writedata, avs_byteenable);
        apt_pkg::OFS_LOWER: state_next.lower = be_merge(state_reg.lower, avs_writedata, avs_byteenable);
        // Byte registers take lane 0 only; the other lanes carry nothing
        apt_pkg::OFS_WR2: begin
          if (avs_byteenable[0]) begin
            state_next.wr2 = avs_writedata[7:0];
          end
        end
        apt_pkg::OFS_WR3: begin
          if (avs_byteenable[0]) begin
            state_next.wr3 = avs_writedata[7:0];
          end
        end
        // Narrow registers keep their low bits; upper lanes are dropped
        apt_pkg::OFS_RANGE: begin
          state_next.range = 24'(be_merge({8'h00, state_reg.range}, avs_writedata, avs_byteenable));
        end
        apt_pkg::OFS_ACCEL: begin
          state_next.accel = 16'(be_merge({16'h0000, state_reg.accel}, avs_writedata, avs_byteenable));
        end
        apt_pkg::OFS_JERK: begin
          state_next.jerk = 16'(be_merge({16'h0000, state_reg.jerk}, avs_writedata, avs_byteenable));
        end
        apt_pkg::OFS_INIT_SPEED: begin
          state_next.init_speed = 16'(be_merge({16'h0000, state_reg.init_speed}, avs_writedata, avs_byteenable));
        end
        apt_pkg::OFS_DRIVE_SPEED: begin
          state_next.drive_speed = 16'(be_merge({16'h0000, state_reg.drive_speed}, avs_writedata, avs_byteenable));
        end
        apt_pkg::OFS_INPUT_MODE: begin
          if (avs_byteenable[0]) begin
            state_next.input_mode = avs_writedata[0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Counters and bounds are cleared too, though software must not rely on it
  // The range starts at a known setting so a fresh axis has a defined pulse rate
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.range <= apt_pkg::RANGE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata = state_reg.rdata;
  assign drive_dir = state_reg.dir;
endmodule // apt_axis

/* rtl/apt_pkg.sv */
// Shared constants and state types for the axis position and pulse timing block
package apt_pkg;
  // Clocking: the pulse timebase runs at half the core clock
  localparam logic [31:0] CLOCK_HZ = 32'h0BEBC200;
  localparam logic [31:0] SCLK_DIV = 32'h00000002;
  localparam logic [31:0] SCLK_HZ = CLOCK_HZ / SCLK_DIV;
  // Parameter scaling figures
  localparam logic [55:0] PPS_SCALE = 56'h7A1200;
  localparam logic [31:0] ACCEL_SCALE = 32'h0000007D;
  localparam logic [55:0] JERK_NUM = 56'h3B9ACA0;
  localparam logic [23:0] RANGE_RESET = 24'h7A1200;
  // Register byte offsets
  localparam logic [7:0] OFS_LPOS = 8'h00;
  localparam logic [7:0] OFS_RPOS = 8'h04;
  localparam logic [7:0] OFS_UPPER = 8'h08;
  localparam logic [7:0] OFS_LOWER = 8'h0C;
  localparam logic [7:0] OFS_WR2 = 8'h10;
  localparam logic [7:0] OFS_WR3 = 8'h14;
  localparam logic [7:0] OFS_RR1 = 8'h18;
  localparam logic [7:0] OFS_RR2 = 8'h1C;
  localparam logic [7:0] OFS_RANGE = 8'h20;
  localparam logic [7:0] OFS_ACCEL = 8'h24;
  localparam logic [7:0] OFS_JERK = 8'h28;
  localparam logic [7:0] OFS_INIT_SPEED = 8'h2C;
  localparam logic [7:0] OFS_DRIVE_SPEED = 8'h30;
  localparam logic [7:0] OFS_COMMAND = 8'h34;
  localparam logic [7:0] OFS_INPUT_MODE = 8'h38;
  localparam logic [7:0] OFS_CUR_SPEED = 8'h3C;
  // Field positions
  localparam int POS_LIMIT_EN_BIT = 0;
  localparam int NEG_LIMIT_EN_BIT = 1;
  localparam int CMP_SRC_BIT = 5;
  localparam int SCURVE_BIT = 2;
  localparam int RING_BIT = 6;
  localparam int UPPER_FLAG_BIT = 0;
  localparam int LOWER_FLAG_BIT = 1;
  localparam int BUSY_BIT = 2;
  localparam int POS_LIM_BIT = 0;
  localparam int NEG_LIM_BIT = 1;
  localparam int CMD_POS_BIT = 0;
  localparam int CMD_NEG_BIT = 1;
  localparam int CMD_DECEL_BIT = 2;
  localparam int CMD_HALT_BIT = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DECEL = 2'b10,
    ST_DRAIN = 2'b11
  } apt_drive_state_type;

  typedef struct packed {
    logic [31:0] lpos;
    logic [31:0] rpos;
    logic [31:0] upper;
    logic [31:0] lower;
    logic [7:0] wr2;
    logic [7:0] wr3;
    logic [23:0] range;
    logic [15:0] accel;
    logic [15:0] jerk;
    logic [15:0] init_speed;
    logic [15:0] drive_speed;
    logic [15:0] speed;
    logic [15:0] cur_accel;
    logic [31:0] acc_v;
    logic [55:0] acc_j;
    logic input_mode;
    logic dir;
    apt_drive_state_type state;
    logic run;
    logic tick;
    logic upper_flag;
    logic lower_flag;
    logic pos_lim;
    logic neg_lim;
    logic ack;
    logic [31:0] rdata;
  } apt_axis_state_type;

  typedef struct packed {
    logic [55:0] acc;
    logic level;
    logic rise;
  } apt_pulse_state_type;

  typedef struct packed {
    logic a1;
    logic b1;
    logic a2;
    logic b2;
    logic a3;
    logic b3;
    logic up;
    logic down;
  } apt_enc_state_type;
endpackage

/* rtl/apt_enc_decode.sv */
// Encoder input synchroniser and quadrature or up/down decoder
`timescale 1ns/1ps
module apt_enc_decode (
  input wire logic clock,
  input wire logic nrst,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic updown_mode,
  output logic count_up,
  output logic count_down
);
  apt_pkg::apt_enc_state_type state_reg;
  apt_pkg::apt_enc_state_type state_next;

  // Two flops per pin, then one more stage that is the previous sample
  always_comb begin
    state_next = state_reg;
    state_next.a1 = enc_a;
    state_next.b1 = enc_b;
    state_next.a2 = state_reg.a1;
    state_next.b2 = state_reg.b1;
    state_next.a3 = state_reg.a2;
    state_next.b3 = state_reg.b2;
    if (updown_mode) begin
      // Separate up and down pulse pins count on rising edges
      state_next.up = state_reg.a2 & ~state_reg.a3;
      state_next.down = state_reg.b2 & ~state_reg.b3;
    end else begin
      // Quadrature, four counts per cycle; a double step is noise and is dropped
      state_next.up = ((state_reg.a2 ^ state_reg.a3) ^ (state_reg.b2 ^ state_reg.b3)) & (state_reg.a2 ^ state_reg.b3);
      state_next.down = ((state_reg.a2 ^ state_reg.a3) ^ (state_reg.b2 ^ state_reg.b3)) & ~(state_reg.a2 ^ state_reg.b3);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count_up = state_reg.up;
  assign count_down = state_reg.down;
endmodule // apt_enc_decode

/* rtl/apt_pulse_gen.sv */
// Drive pulse generator: half periods in whole timebase ticks, mixed to hit the mean rate
`timescale 1ns/1ps
module apt_pulse_gen (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sclk_tick,
  input wire logic run,
  input wire logic [15:0] speed,
  input wire logic [23:0] range,
  output logic pulse_level,
  output logic pulse_rise
);
  apt_pkg::apt_pulse_state_type state_reg;
  apt_pkg::apt_pulse_state_type state_next;
  logic [55:0] step;
  logic [55:0] thr;
  logic [55:0] sum;

  // Two half periods per pulse: rate = speed * 8e6 / range
  assign step = 56'(speed) * (apt_pkg::PPS_SCALE + apt_pkg::PPS_SCALE);
  assign thr = 56'(range) * 56'(apt_pkg::SCLK_HZ);
  assign sum = state_reg.acc + step;

  // The residue carries over, so two neighbouring periods alternate in proportion
  always_comb begin
    state_next = state_reg;
    state_next.rise = 1'b0;
    if (sclk_tick && (run || state_reg.level)) begin
      if (sum >= thr) begin
        state_next.acc = sum - thr;
        state_next.level = ~state_reg.level;
        state_next.rise = ~state_reg.level;
      end else begin
        state_next.acc = sum;
      end
    end
    if (!run && !state_reg.level) begin
      state_next.acc = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pulse_level = state_reg.level;
  assign pulse_rise = state_reg.rise;
endmodule // apt_pulse_gen

/* verif/apt_axis_sva.sv */
// Checker for the register slave handshake and the drive pulse outputs of one axis
`timescale 1ns/1ps
module apt_axis_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic drive_pulse,
  input wire logic drive_dir
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Stages of one bus transfer
  sequence req_new; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence rd_done; avs_read && !avs_waitrequest; endsequence
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait cycle");
  one_wait_a: assert property (req_new |=> !avs_waitrequest) else $error("answer late");
  idle_free_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
  unmapped_zero_a: assert property (rd_done and avs_address > 8'h3C |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  flags_width_a: assert property (rd_done and avs_address == 8'h18 |-> avs_readdata[31:3] == 29'h0)
    else $error("status read wide");
  limit_width_a: assert property (rd_done and avs_address == 8'h1C |-> avs_readdata[31:2] == 30'h0)
    else $error("limit read wide");
  high_whole_a: assert property ($rose(drive_pulse) |=> drive_pulse) else $error("high half short");
  low_whole_a: assert property ($fell(drive_pulse) |=> !drive_pulse) else $error("low half short");
  dir_hold_a: assert property (drive_pulse |-> $stable(drive_dir)) else $error("direction moved");
endmodule // apt_axis_sva
bind apt_axis apt_axis_sva u_sva (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enc_a(enc_a), .enc_b(enc_b),
  .drive_pulse(drive_pulse), .drive_dir(drive_dir));

/* verif/apt_enc_model.sv */
// Encoder model: quadrature steps or separate up and down pulses
`timescale 1ns/1ps
module apt_enc_model (
  input wire logic clock,
  output logic enc_a,
  output logic enc_b
);
  int k;
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    k = 0;
  end
  // Levels stand 4 clocks so the input synchroniser never misses one
  task automatic hold();
    repeat (4) @(posedge clock);
  endtask
  // Up pulses on the first pin, then down pulses on the second
  task automatic pulses(input int n_up, input int n_dn);
    for (int i = 0; i < n_up + n_dn; i++) begin
      if (i < n_up) enc_a <= 1'b1;
      else enc_b <= 1'b1;
      hold();
      enc_a <= 1'b0;
      enc_b <= 1'b0;
      hold();
    end
  endtask
  // Gray steps, first pin leading when forward
  task automatic quad(input int edges, input logic fwd);
    for (int i = 0; i < edges; i++) begin
      k = fwd ? (k + 1) % 4 : (k + 3) % 4;
      enc_a <= (k == 1) || (k == 2);
      enc_b <= (k >= 2);
      hold();
    end
  endtask
endmodule // apt_enc_model

/* verif/tb.sv */
// Self-checking bench for one axis: registers, compare, limits, ring and drive
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t %h/%h", $time, g, e); end end
module tb;
  logic clock, nrst, avs_read, avs_write, avs_waitrequest, enc_a, enc_b, drive_pulse, drive_dir, pp;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  int n_mismatch, cmp_count, nrise, n;
  apt_axis u_dut (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .enc_a(enc_a), .enc_b(enc_b), .drive_pulse(drive_pulse),
    .drive_dir(drive_dir));
  apt_enc_model u_enc (.clock(clock), .enc_a(enc_a), .enc_b(enc_b));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Rises counted mid-cycle, away from the edge that moves the pin
  always @(negedge clock) begin
    if (drive_pulse === 1'b1 && pp === 1'b0) nrise++;
    pp = drive_pulse;
  end
  task close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Request held until an edge that sees waitrequest low
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clock);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && t < 50) begin
      @(posedge clock);
      t++;
    end
    if (t >= 50) n_mismatch++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // Busy polled with a bound; a stuck drive counts as a mismatch
  task wait_idle();
    int t;
    t = 0;
    q = 32'h4;
    while (q[2] !== 1'b0 && t < 4000) begin
      xfer(1'b0, apt_pkg::OFS_RR1, 32'h0);
      t++;
    end
    if (t >= 4000) n_mismatch++;
  endtask
  // Runs n pulses at constant speed, measures one high half, then halts
  task drive(input logic [31:0] cmd, input int n_want);
    int hi;
    hi = 0;
    nrise = 0;
    wr(apt_pkg::OFS_COMMAND, cmd);
    // Let the high half in progress end, then time a whole one from its first sample
    while ((nrise < n_want || drive_pulse !== 1'b0) && hi < 9000) begin
      @(negedge clock);
      hi++;
    end
    while (drive_pulse !== 1'b1 && hi < 9000) begin
      @(negedge clock);
      hi++;
    end
    if (hi >= 9000) n_mismatch++;
    hi = 0;
    while (drive_pulse === 1'b1 && hi < 999) begin
      @(negedge clock);
      hi++;
    end
    `CHK(hi, 100)
    `CHK(drive_dir, cmd[1])
    wr(apt_pkg::OFS_COMMAND, 32'h8);
    wait_idle();
    n = nrise;
  endtask
  initial begin
    {nrst, avs_read, avs_write, pp} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    wr(apt_pkg::OFS_UPPER, 32'h0000270F);
    chk(apt_pkg::OFS_UPPER, 32'h0000270F);
    wr(apt_pkg::OFS_LOWER, 32'hFFFFFC18);
    chk(apt_pkg::OFS_LOWER, 32'hFFFFFC18);
    wr(apt_pkg::OFS_LPOS, 32'h80000000);
    chk(apt_pkg::OFS_LPOS, 32'h80000000);
    chk(8'h40, 32'h0);
    chk(apt_pkg::OFS_RR1, 32'h2);
    wr(apt_pkg::OFS_LPOS, 32'h00002710);
    chk(apt_pkg::OFS_RR1, 32'h1);
    wr(apt_pkg::OFS_LPOS, 32'h0000270F);
    chk(apt_pkg::OFS_RR1, 32'h0);
    wr(apt_pkg::OFS_RPOS, 32'hFFFFFC17);
    wr(apt_pkg::OFS_WR2, 32'h20);
    chk(apt_pkg::OFS_RR1, 32'h2);
    wr(apt_pkg::OFS_WR2, 32'h0);
    $display("compare test ended");
    // Range 800 gives 1 MHz at speed 100: 200 clocks a pulse
    wr(apt_pkg::OFS_RANGE, 32'h320);
    wr(apt_pkg::OFS_INIT_SPEED, 32'h64);
    wr(apt_pkg::OFS_DRIVE_SPEED, 32'h64);
    wr(apt_pkg::OFS_LPOS, 32'hFFFFFFFF);
    drive(32'h1, 3);
    chk(apt_pkg::OFS_LPOS, 32'hFFFFFFFF + 32'(n));
    wr(apt_pkg::OFS_LPOS, 32'h0);
    drive(32'h2, 2);
    chk(apt_pkg::OFS_LPOS, 32'h0 - 32'(n));
    wr(apt_pkg::OFS_WR3, 32'h40);
    wr(apt_pkg::OFS_LPOS, 32'h0000270E);
    drive(32'h1, 3);
    chk(apt_pkg::OFS_LPOS, 32'((9998 + n) % 10000));
    wr(apt_pkg::OFS_LPOS, 32'h1);
    drive(32'h2, 3);
    chk(apt_pkg::OFS_LPOS, 32'((10001 - n) % 10000));
    wr(apt_pkg::OFS_ACCEL, 32'hFFFF);
    wr(apt_pkg::OFS_DRIVE_SPEED, 32'h78);
    wr(apt_pkg::OFS_COMMAND, 32'h1);
    repeat (1500) @(posedge clock);
    chk(apt_pkg::OFS_CUR_SPEED, 32'h78);
    wr(apt_pkg::OFS_COMMAND, 32'h4);
    wait_idle();
    chk(apt_pkg::OFS_CUR_SPEED, 32'h64);
    $display("drive test ended");
    wr(apt_pkg::OFS_INPUT_MODE, 32'h1);
    wr(apt_pkg::OFS_LOWER, 32'h3);
    wr(apt_pkg::OFS_RPOS, 32'h3);
    u_enc.pulses(2, 0);
    chk(apt_pkg::OFS_RPOS, 32'h1);
    wr(apt_pkg::OFS_WR3, 32'h0);
    wr(apt_pkg::OFS_RPOS, 32'h0);
    u_enc.pulses(5, 2);
    chk(apt_pkg::OFS_RPOS, 32'h3);
    wr(apt_pkg::OFS_INPUT_MODE, 32'h0);
    wr(apt_pkg::OFS_RPOS, 32'hA);
    u_enc.quad(8, 1'b1);
    chk(apt_pkg::OFS_RPOS, 32'h12);
    u_enc.quad(8, 1'b0);
    chk(apt_pkg::OFS_RPOS, 32'hA);
    $display("encoder test ended");
    wr(apt_pkg::OFS_WR2, 32'h1);
    wr(apt_pkg::OFS_UPPER, 32'h3);
    wr(apt_pkg::OFS_LPOS, 32'h0);
    wr(apt_pkg::OFS_COMMAND, 32'h1);
    wait_idle();
    chk(apt_pkg::OFS_RR2, 32'h1);
    wr(apt_pkg::OFS_UPPER, 32'h7FFFFFFF);
    chk(apt_pkg::OFS_RR2, 32'h0);
    wr(apt_pkg::OFS_WR2, 32'h2);
    wr(apt_pkg::OFS_LOWER, 32'hFFFFFFFD);
    wr(apt_pkg::OFS_COMMAND, 32'h2);
    wait_idle();
    chk(apt_pkg::OFS_RR2, 32'h2);
    $display("limit test ended");
    close_out();
  end
  // Watchdog well past the expected run of some 40000 ns
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
endmodule // tb
